/* common/idle_wake_defines.svh */
`ifndef IDLE_WAKE_DEFINES_SVH
`define IDLE_WAKE_DEFINES_SVH

// Register-file offsets
`define IDLE_WAKE_ENABLE_ADDR 8'hC6
`define STATUS_WORD_ADDR      8'hD0

// Wake enable fields
`define WAKE_ON_EXT_IRQ_ZERO_BIT 0
`define WAKE_ON_EXT_IRQ_ONE_BIT  1
`define WAKE_ON_WATCHDOG_BIT     2
`define WAKE_ENABLE_WIDTH        3
`define WAKE_ENABLE_RESET        3'h0

// Bank select field of the status word
`define BANK_SEL_LSB   3
`define BANK_SEL_MSB   4
`define BANK_SEL_RESET 2'h0

`endif

/* common/idle_wake_pkg.sv */
package idle_wake_pkg;

  typedef enum logic
  {
    CORE_RUN,
    CORE_IDLE
  } core_state_t;

  typedef logic [7:0]  sfr_byte_t;
  typedef logic [15:0] code_addr_t;
  typedef logic [1:0]  bank_sel_t;

endpackage : idle_wake_pkg

/* logic/idle_wake_ctrl.sv */
// Functional notes
// - Idle core woken by aux and optional sources
// - Wake enable bit 2 gates watchdog wake
// - Wake enable bit 1 gates external irq one
// - Wake enable bit 0 gates external irq zero
// - Enabled source in idle resumes the core
// - Disabled source never ends idle mode
// - Only interrupt return ends interrupt service
// - Interrupt return address taken from stack top
// - Working register zero maps per selected bank
// - Bank zero selected by default
// - Aux enable gates aux irq without global enable
`timescale 1ns/1ps
`include "idle_wake_defines.svh"

module idle_wake_ctrl
  import idle_wake_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  input  wire logic       idle_enter_i,
  input  wire logic       wdt_irq_i,
  input  wire logic       ext_irq_one_i,
  input  wire logic       ext_irq_zero_i,
  input  wire logic       aux_irq_i,
  input  wire logic       aux_irq_enable_i,
  input  wire logic       global_irq_enable_i,
  output logic            idle_o,
  output logic            wake_o,
  input  wire logic       irq_accept_i,
  input  wire logic       return_from_interrupt_i,
  input  wire logic       plain_return_i,
  input  wire logic [15:0] stack_top_i,
  output logic            in_service_o,
  output logic            pc_load_o,
  output logic     [15:0] ret_addr_o,
  input  wire logic [2:0] reg_index_i,
  output logic      [7:0] working_reg_addr_o
);

  logic [`WAKE_ENABLE_WIDTH-1:0] wake_en_q;
  bank_sel_t                     bank_q;
  core_state_t                   state_q;
  logic                          aux_wake;
  logic                          wake_cause;
  logic                          wake_en_wr;

  assign wake_en_wr = sfr_wr_i && (sfr_addr_i == `IDLE_WAKE_ENABLE_ADDR);

  // Wake enable register
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      wake_en_q <= `WAKE_ENABLE_RESET;
    else if (wake_en_wr)
      wake_en_q <= sfr_wdata_i[`WAKE_ENABLE_WIDTH-1:0];
  end

  // Register readback, unused bits read zero
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      sfr_rdata_o <= 8'h00;
    else if (sfr_addr_i == `IDLE_WAKE_ENABLE_ADDR)
      sfr_rdata_o <= {5'h00, wake_en_q};
    else if (sfr_addr_i == `STATUS_WORD_ADDR)
      sfr_rdata_o <= {3'h0, bank_q, 3'h0};
    else
      sfr_rdata_o <= 8'h00;
  end

  // Aux irq uses its own enable only
  assign aux_wake = aux_irq_i && aux_irq_enable_i;

  // Wake sources
  assign wake_cause = aux_wake
    || (wake_en_q[`WAKE_ON_WATCHDOG_BIT] && wdt_irq_i)
    || (wake_en_q[`WAKE_ON_EXT_IRQ_ONE_BIT] && ext_irq_one_i)
    || (wake_en_q[`WAKE_ON_EXT_IRQ_ZERO_BIT] && ext_irq_zero_i);

  // Idle state
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state_q <= CORE_RUN;
    else
    begin
      unique case (state_q)
        CORE_RUN:
          if (idle_enter_i)
            state_q <= CORE_IDLE;
        CORE_IDLE:
          if (wake_cause)
            state_q <= CORE_RUN;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      idle_o <= 1'b0;
    else
      idle_o <= (state_q == CORE_IDLE) ? !wake_cause : idle_enter_i;
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      wake_o <= 1'b0;
    else
      wake_o <= (state_q == CORE_IDLE) && wake_cause;
  end

  // In-service flag, accept wins over return
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      in_service_o <= 1'b0;
    else if (irq_accept_i)
      in_service_o <= 1'b1;
    else if (return_from_interrupt_i)
      in_service_o <= 1'b0;
  end

  // Return address from stack top
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pc_load_o  <= 1'b0;
      ret_addr_o <= 16'h0000;
    end
    else
    begin
      pc_load_o <= return_from_interrupt_i || plain_return_i;
      if (return_from_interrupt_i || plain_return_i)
        ret_addr_o <= stack_top_i;
    end
  end

  // Register bank select
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      bank_q <= `BANK_SEL_RESET;
    else if (sfr_wr_i && (sfr_addr_i == `STATUS_WORD_ADDR))
      bank_q <= sfr_wdata_i[`BANK_SEL_MSB:`BANK_SEL_LSB];
  end

  // Working register address
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      working_reg_addr_o <= 8'h00;
    else
      working_reg_addr_o <= {3'h0, bank_q, reg_index_i};
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  a_wdt_wake_gate: assert property (
    (state_q == CORE_IDLE) && wdt_irq_i && wake_en_q[2] |=> wake_o && !idle_o)
    else $error("watchdog did not wake idle core");

  a_ext_one_wake: assert property (
    (state_q == CORE_IDLE) && ext_irq_one_i && wake_en_q[1] |=> state_q == CORE_RUN)
    else $error("external irq one did not wake core");

  a_ext_zero_wake: assert property (
    (state_q == CORE_IDLE) && ext_irq_zero_i && wake_en_q[0] |=> wake_o)
    else $error("external irq zero did not wake core");

  a_disabled_no_wake: assert property (
    (state_q == CORE_IDLE) && !aux_wake && !(wdt_irq_i && wake_en_q[2])
      && !(ext_irq_one_i && wake_en_q[1]) && !(ext_irq_zero_i && wake_en_q[0])
      |=> idle_o && !wake_o)
    else $error("idle ended without enabled source");

  a_aux_wake_any: assert property (
    (state_q == CORE_IDLE) && aux_irq_i && aux_irq_enable_i && !global_irq_enable_i
      |=> wake_o)
    else $error("aux irq failed to wake core");

  a_plain_ret_keeps: assert property (
    in_service_o && plain_return_i && !return_from_interrupt_i |=> in_service_o)
    else $error("plain return ended service");

  a_return_from_interrupt_ends: assert property (
    return_from_interrupt_i && !irq_accept_i |=> !in_service_o)
    else $error("interrupt return did not end service");

  a_ret_addr_stack: assert property (
    return_from_interrupt_i |=> pc_load_o && ret_addr_o == $past(stack_top_i))
    else $error("return address not from stack top");

  a_bank_mapping: assert property (
    reg_index_i == 3'h0 |=> working_reg_addr_o == {3'h0, $past(bank_q), 3'h0})
    else $error("register zero mapped wrongly");

  a_upper_bits_zero: assert property (
    sfr_addr_i == `IDLE_WAKE_ENABLE_ADDR |=> sfr_rdata_o[7:3] == 5'h00)
    else $error("unused wake bits not zero");

  a_idle_entry_taken: assert property (
    (state_q == CORE_RUN) && idle_enter_i |=> idle_o && (state_q == CORE_IDLE))
    else $error("idle request not taken");

  a_idle_flag_state: assert property (
    idle_o == (state_q == CORE_IDLE))
    else $error("idle flag disagrees with state");

  a_wake_pulse_single: assert property (
    wake_o |=> !wake_o)
    else $error("wake pulse longer than one cycle");

  a_wake_ends_idle: assert property (
    wake_o |-> !idle_o && (state_q == CORE_RUN))
    else $error("wake pulse while still idle");

  a_run_no_wake: assert property (
    (state_q == CORE_RUN) |=> !wake_o)
    else $error("wake pulse without idle");

  a_enabled_source_wake: assert property (
    (state_q == CORE_IDLE) && wake_cause |=> wake_o && (state_q == CORE_RUN))
    else $error("enabled source did not resume core");

  a_wdt_off_blocks: assert property (
    (state_q == CORE_IDLE) && wdt_irq_i && !wake_en_q[`WAKE_ON_WATCHDOG_BIT] && !aux_wake
      && !ext_irq_one_i && !ext_irq_zero_i |=> idle_o)
    else $error("disabled watchdog woke core");

  a_ext_one_off: assert property (
    (state_q == CORE_IDLE) && ext_irq_one_i && !wake_en_q[`WAKE_ON_EXT_IRQ_ONE_BIT]
      && !aux_wake && !wdt_irq_i && !ext_irq_zero_i |=> idle_o)
    else $error("disabled external irq one woke core");

  a_ext_zero_off: assert property (
    (state_q == CORE_IDLE) && ext_irq_zero_i && !wake_en_q[`WAKE_ON_EXT_IRQ_ZERO_BIT]
      && !aux_wake && !wdt_irq_i && !ext_irq_one_i |=> idle_o)
    else $error("disabled external irq zero woke core");

  a_aux_off_blocks: assert property (
    (state_q == CORE_IDLE) && aux_irq_i && !aux_irq_enable_i && !wdt_irq_i
      && !ext_irq_one_i && !ext_irq_zero_i |=> idle_o)
    else $error("disabled aux irq woke core");

  a_aux_wake_global: assert property (
    (state_q == CORE_IDLE) && aux_irq_i && aux_irq_enable_i && global_irq_enable_i
      |=> wake_o && !idle_o)
    else $error("aux irq failed to wake core");

  a_wake_en_write: assert property (
    wake_en_wr
      |=> wake_en_q == $past(sfr_wdata_i[`WAKE_ENABLE_WIDTH-1:0]))
    else $error("wake enable write lost");

  a_wake_en_hold: assert property (
    !wake_en_wr |=> $stable(wake_en_q))
    else $error("wake enable changed without write");

  a_wake_readback: assert property (
    sfr_addr_i == `IDLE_WAKE_ENABLE_ADDR
      |=> sfr_rdata_o[`WAKE_ENABLE_WIDTH-1:0] == $past(wake_en_q))
    else $error("wake enable readback wrong");

  a_accept_sets: assert property (
    irq_accept_i |=> in_service_o)
    else $error("accept did not start service");

  a_service_holds: assert property (
    !irq_accept_i && !return_from_interrupt_i |=> $stable(in_service_o))
    else $error("service flag changed without cause");

  a_pc_load_pulse: assert property (
    !return_from_interrupt_i && !plain_return_i |=> !pc_load_o)
    else $error("pc load without return");

  a_ret_addr_hold: assert property (
    !return_from_interrupt_i && !plain_return_i |=> $stable(ret_addr_o))
    else $error("return address changed without return");

  a_bank_write: assert property (
    sfr_wr_i && (sfr_addr_i == `STATUS_WORD_ADDR)
      |=> bank_q == $past(sfr_wdata_i[`BANK_SEL_MSB:`BANK_SEL_LSB]))
    else $error("bank select write lost");

  a_bank_hold: assert property (
    !(sfr_wr_i && (sfr_addr_i == `STATUS_WORD_ADDR)) |=> $stable(bank_q))
    else $error("bank changed without write");

  a_bank_readback: assert property (
    sfr_addr_i == `STATUS_WORD_ADDR
      |=> sfr_rdata_o == {3'h0, $past(bank_q), 3'h0})
    else $error("bank readback wrong");

  a_reg_addr_any: assert property (
    1'b1
      |=> working_reg_addr_o == {3'h0, $past(bank_q), $past(reg_index_i)})
    else $error("working register address wrong");

endmodule : idle_wake_ctrl

/* testbench/irq_source_model.sv */
`timescale 1ns/1ps
module irq_source_model
(
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  input  wire logic [3:0] fire_i,
  output logic      [3:0] irq_o
);
  // Levels follow requests one cycle late
  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i)
      irq_o <= 4'h0;
    else
      irq_o <= fire_i;
endmodule : irq_source_model

/* testbench/idle_wakeup_and_irq_return_tb.sv */
`timescale 1ns/1ps
module idle_wakeup_and_irq_return_tb;
  logic        sys_clk_i = 1'b0;
  logic        resetn_i, sfr_wr_i, idle_enter_i, aux_irq_enable_i, global_irq_enable_i;
  logic        irq_accept_i, return_from_interrupt_i, plain_return_i;
  logic        idle_o, wake_o, in_service_o, pc_load_o;
  wire         wdt_irq_i, ext_irq_one_i, ext_irq_zero_i, aux_irq_i;
  logic [7:0]  sfr_addr_i, sfr_wdata_i, sfr_rdata_o, working_reg_addr_o;
  logic [15:0] stack_top_i, ret_addr_o;
  logic [3:0]  fire;
  logic [2:0]  reg_index_i;
  logic [31:0] rnd = 32'h058C;
  int          miscompares, num_checks, cycles, wake;

  idle_wake_ctrl idle_wake_ctrl_i (.sys_clk_i, .resetn_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
    .sfr_rdata_o, .idle_enter_i, .wdt_irq_i, .ext_irq_one_i, .ext_irq_zero_i, .aux_irq_i,
    .aux_irq_enable_i, .global_irq_enable_i, .idle_o, .wake_o, .irq_accept_i,
    .return_from_interrupt_i, .plain_return_i, .stack_top_i, .in_service_o, .pc_load_o,
    .ret_addr_o, .reg_index_i, .working_reg_addr_o);
  irq_source_model irq_source_model_i (.sys_clk_i, .resetn_i, .fire_i(fire),
    .irq_o({aux_irq_i, wdt_irq_i, ext_irq_one_i, ext_irq_zero_i}));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task chk(input logic [17:0] seen, input logic [17:0] exp);
    num_checks++;
    miscompares += (seen !== exp);
    if (seen !== exp)
      $display("[ERR] %0t %0h %0h", $time, seen, exp);
  endtask : chk
  task wr(input logic [15:0] ad);
    @(posedge sys_clk_i) {sfr_addr_i, sfr_wdata_i, sfr_wr_i} <= {ad, 1'b1};
    @(posedge sys_clk_i) sfr_wr_i <= 1'b0;
    @(posedge sys_clk_i) #1;
  endtask : wr
  task summarize(input int late);
    miscompares += late;
    $display("%0d checks %0d miscompares", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
    if (++cycles == 3000)
      summarize(1);

  initial
  begin
    {resetn_i, sfr_wr_i, idle_enter_i, aux_irq_enable_i, global_irq_enable_i} = '0;
    {irq_accept_i, return_from_interrupt_i, plain_return_i, sfr_wdata_i, stack_top_i} = '0;
    {sfr_addr_i, fire, reg_index_i} = {8'hC6, 7'h00};
    repeat (12) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i) #1;
    chk({sfr_rdata_o, working_reg_addr_o}, 16'h0000);
    wr(16'hC6FF);
    chk(sfr_rdata_o, 8'h07);
    // Random enables, source and bank per pass
    for (int i = 0; i < 12; i++)
    begin
      rnd = lfsr(rnd);
      wake = (rnd[4:3] == 2'h3) ? rnd[5] : rnd[rnd[4:3]];
      wr({8'hC6, rnd[7:0]});
      chk(sfr_rdata_o, rnd[2:0]);
      @(posedge sys_clk_i) {idle_enter_i, reg_index_i, aux_irq_enable_i, global_irq_enable_i}
        <= {1'b1, rnd[10:8], rnd[5], rnd[6]};
      @(posedge sys_clk_i) idle_enter_i <= 1'b0;
      fire <= 4'h1 << rnd[4:3];
      #1 chk(idle_o, 1'b1);
      repeat (2) @(posedge sys_clk_i);
      #1 chk({idle_o, wake_o}, wake ? 2'h1 : 2'h2);
      @(posedge sys_clk_i) {fire, aux_irq_enable_i} <= 5'h11;
      repeat (2) @(posedge sys_clk_i);
      #1 chk(idle_o, 1'b0);
      @(posedge sys_clk_i) fire <= 4'h0;
      wr({8'hD0, 3'h0, rnd[12:11], 3'h0});
      chk(working_reg_addr_o, {rnd[12:11], rnd[10:8]});
    end
    // Accept, plain return, then interrupt return
    @(posedge sys_clk_i) irq_accept_i <= 1'b1;
    @(posedge sys_clk_i) {irq_accept_i, plain_return_i} <= 2'h1;
    @(posedge sys_clk_i) {plain_return_i, return_from_interrupt_i} <= 2'h1;
    stack_top_i <= rnd[31:16];
    #1 chk({in_service_o, pc_load_o}, 2'h3);
    @(posedge sys_clk_i) return_from_interrupt_i <= 1'b0;
    #1 chk({in_service_o, pc_load_o, ret_addr_o}, {2'h1, rnd[31:16]});
    summarize(0);
  end
endmodule : idle_wakeup_and_irq_return_tb
